// [bridge_side_model.sv]
`timescale 1ns/1ps
// Bridge settings as configuring software presents them.
module bridge_side_model (
  input  wire logic        vga_on,
  input  wire logic        isa_on,
  input  wire logic        want_present,
  output logic             vga_enable,
  output logic             isa_enable,
  output logic      [15:0] io_window_base,
  output logic      [15:0] io_window_limit,
  output logic      [7:0]  present_wdata
);
  // The window covers the legacy ports so the base and limit path is reached.
  assign vga_enable = vga_on;
  assign isa_enable = isa_on;
  assign io_window_base = 16'h0300;
  assign io_window_limit = 16'h03FF;
  // Software never sets the present bit while VGA enable is clear.
  assign present_wdata = {2'h0, want_present & vga_on, 5'h00};
endmodule

// [legacy_route_and_strap_bits.sv]
`timescale 1ns/1ps
// Contract
// - Writable bit 5 marks monochrome adapter present.
// - VGA clear: 3BC-3BF decoded as ordinary I/O.
// - Memory B0000-B7FFF is monochrome adapter memory.
// - Listed I/O ports match, A[15:10] ignored.
// - Any touch of monochrome port goes hub, except in VGA only and at 3BF with VGA clear.
// - Both clear: legacy references go hub, except 3BC-3BF.
// - VGA only: VGA to bridge, 3BF hub.
// - Both set: VGA graphics, monochrome hub.
// - Bit 3 mirrors graphics port strap.
// - Bit 2 selects queue depth 1 or 12.
// - Bits 1:0 latch bus speed straps.
// - Frequency codes 100/400, 133/533, 200/800, reserved.
module legacy_route_and_strap_bits (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        cfg_write,
  input  wire logic [7:0]  cfg_wdata,
  output logic      [7:0]  cfg_rdata,
  input  wire logic        power_good,
  input  wire logic        graphics_port_strap,
  input  wire logic        host_addr7_strap_pin,
  input  wire logic [1:0]  bus_speed_select_pins,
  input  wire logic        vga_enable,
  input  wire logic        isa_enable,
  input  wire logic [15:0] io_window_base,
  input  wire logic [15:0] io_window_limit,
  input  wire logic        req_valid,
  input  wire logic        req_is_io,
  input  wire logic [31:0] req_addr,
  input  wire logic [3:0]  req_byte_en,
  output logic      [1:0]  route_dest_r,
  output logic             route_valid_r,
  output logic      [3:0]  inorder_queue_depth,
  output logic      [1:0]  front_bus_freq_select,
  output logic             illegal_combination
);
  logic       mono_adapter_present_r;
  logic       mono_adapter_present_nxt;
  logic [3:0] strap_r;
  logic [1:0] route_dest_nxt;
  logic       route_valid_nxt;
  logic       io_mono_hit;
  logic       io_vga_hit;
  logic       io_3bf_hit;
  logic       io_3bc_range;
  logic       io_in_window;
  logic       mem_mono_hit;
  logic       mem_vga_hit;
  logic       legacy_hit;
  logic       mono_hit;

  // True when a 10-bit I/O address, aliases folded away, is a monochrome port.
  function automatic logic is_mono_port(input logic [9:0] a);
    is_mono_port = (a == legacy_route_pkg::MONO_IO_3B4) || (a == legacy_route_pkg::MONO_IO_3B5) ||
                   (a == legacy_route_pkg::MONO_IO_3B8) || (a == legacy_route_pkg::MONO_IO_3B9) ||
                   (a == legacy_route_pkg::MONO_IO_3BA) || (a == legacy_route_pkg::MONO_IO_3BF);
  endfunction

  // Byte address of one enabled lane of a dword I/O reference, A[15:10] dropped.
  function automatic logic [9:0] lane_addr(input logic [31:0] a, input int lane);
    lane_addr = {a[9:2], 2'(lane)};
  endfunction

  // Straps are latched once per power-good rise and never written by software.
  strap_capture #(.WIDTH(4)) u_straps (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .power_good (power_good),
    .strap_in   ({graphics_port_strap, host_addr7_strap_pin, bus_speed_select_pins}),
    .strap_r    (strap_r)
  );

  // Configuration byte: only the present bit takes writes; strap bits come from latches.
  always_comb begin
    mono_adapter_present_nxt = mono_adapter_present_r;
    if (cfg_write) begin
      mono_adapter_present_nxt = cfg_wdata[legacy_route_pkg::MONO_PRESENT_BIT];
    end
  end

  // Read view of the configuration byte; unused bits read as zero.
  always_comb begin
    cfg_rdata = legacy_route_pkg::CFG_RESET;
    cfg_rdata[legacy_route_pkg::MONO_PRESENT_BIT] = mono_adapter_present_r;
    cfg_rdata[legacy_route_pkg::GFX_MODE_BIT]     = strap_r[3];
    cfg_rdata[legacy_route_pkg::QUEUE_DEPTH_BIT]  = strap_r[2];
    cfg_rdata[legacy_route_pkg::FREQ_MSB:legacy_route_pkg::FREQ_LSB] = strap_r[1:0];
  end

  // Decoded strap meanings offered to the bus and hub logic.
  assign inorder_queue_depth = strap_r[2] ? legacy_route_pkg::QUEUE_DEPTH_DEEP
                                          : legacy_route_pkg::QUEUE_DEPTH_SHALLOW;
  assign front_bus_freq_select = strap_r[1:0];
  // Flagged rather than corrected; software is expected never to set it.
  assign illegal_combination = mono_adapter_present_r && !vga_enable;

  // Address decode; every enabled byte lane is checked so a wide reference cannot slip past.
  always_comb begin
    io_mono_hit = 1'b0;
    io_vga_hit  = 1'b0;
    io_3bf_hit  = 1'b0;
    for (int lane = 0; lane < 4; lane++) begin
      if (req_byte_en[lane]) begin
        if (is_mono_port(lane_addr(req_addr, lane))) begin
          io_mono_hit = 1'b1;
        end
        if (lane_addr(req_addr, lane) == legacy_route_pkg::MONO_IO_3BF) begin
          io_3bf_hit = 1'b1;
        end
        if ((lane_addr(req_addr, lane) >= legacy_route_pkg::VGA_IO_LO) &&
            (lane_addr(req_addr, lane) <= legacy_route_pkg::VGA_IO_HI) &&
            !is_mono_port(lane_addr(req_addr, lane))) begin
          io_vga_hit = 1'b1;
        end
      end
    end
  end

  assign io_3bc_range = (req_addr[9:2] == legacy_route_pkg::PORT_3BC[9:2]);
  assign io_in_window = (req_addr[15:0] >= io_window_base) && (req_addr[15:0] <= io_window_limit);
  assign mem_mono_hit = (req_addr >= legacy_route_pkg::MONO_MEM_LO) &&
                        (req_addr <= legacy_route_pkg::MONO_MEM_HI);
  assign mem_vga_hit  = (req_addr >= legacy_route_pkg::VGA_MEM_LO) &&
                        (req_addr <= legacy_route_pkg::VGA_MEM_HI);
  assign legacy_hit   = req_is_io ? (io_mono_hit || io_vga_hit) : mem_vga_hit;
  assign mono_hit     = req_is_io ? io_mono_hit : mem_mono_hit;

  // Routing decision, registered one cycle after the request.
  always_comb begin
    route_valid_nxt = req_valid;
    route_dest_nxt  = legacy_route_pkg::DEST_NONE;
    if (req_valid) begin
      if (!vga_enable && req_is_io && io_3bc_range) begin
        route_dest_nxt = (io_in_window && !isa_enable) ? legacy_route_pkg::DEST_GRAPHICS
                                                       : legacy_route_pkg::DEST_HUB;
      end else if (legacy_hit && !vga_enable) begin
        route_dest_nxt = legacy_route_pkg::DEST_HUB;
      end else if (legacy_hit && !mono_adapter_present_r) begin
        route_dest_nxt = (req_is_io && io_3bf_hit) ? legacy_route_pkg::DEST_HUB
                                                   : legacy_route_pkg::DEST_GRAPHICS;
      end else if (legacy_hit) begin
        route_dest_nxt = mono_hit ? legacy_route_pkg::DEST_HUB
                                  : legacy_route_pkg::DEST_GRAPHICS;
      end else if (req_is_io) begin
        route_dest_nxt = (io_in_window && !isa_enable) ? legacy_route_pkg::DEST_GRAPHICS
                                                       : legacy_route_pkg::DEST_HUB;
      end else begin
        route_dest_nxt = legacy_route_pkg::DEST_HUB;
      end
    end
  end

  // State registers.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mono_adapter_present_r <= 1'b0;
      route_dest_r           <= legacy_route_pkg::DEST_NONE;
      route_valid_r          <= 1'b0;
    end else begin
      mono_adapter_present_r <= mono_adapter_present_nxt;
      route_dest_r           <= route_dest_nxt;
      route_valid_r          <= route_valid_nxt;
    end
  end
endmodule

// [legacy_route_and_strap_bits_tb.sv]
`timescale 1ns/1ps
module legacy_route_and_strap_bits_tb;
  logic        clk_sys = 1'b0, rst = 1'b1, cfg_write = 1'b0, power_good = 1'b0;
  logic        graphics_port_strap = 1'b0, host_addr7_strap_pin = 1'b0, req_valid = 1'b0, req_is_io = 1'b0;
  logic        vga_on = 1'b0, isa_on = 1'b0, want_present = 1'b0, vga_enable, isa_enable, route_valid_r;
  logic        illegal_combination;
  logic [1:0]  bus_speed_select_pins = 2'h0, route_dest_r, front_bus_freq_select;
  logic [3:0]  req_byte_en = 4'h0, inorder_queue_depth;
  logic [7:0]  cfg_wdata = 8'h00, cfg_rdata, present_wdata;
  logic [15:0] io_window_base, io_window_limit;
  logic [31:0] req_addr = 32'h0;
  int          n_mismatch = 0, checked = 0, cycles = 0;

  always #5 clk_sys = ~clk_sys;

  legacy_route_and_strap_bits legacy_route_and_strap_bits_inst (
    .clk_sys(clk_sys), .rst(rst), .cfg_write(cfg_write), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .power_good(power_good), .graphics_port_strap(graphics_port_strap),
    .host_addr7_strap_pin(host_addr7_strap_pin), .bus_speed_select_pins(bus_speed_select_pins),
    .vga_enable(vga_enable), .isa_enable(isa_enable), .io_window_base(io_window_base),
    .io_window_limit(io_window_limit), .req_valid(req_valid), .req_is_io(req_is_io), .req_addr(req_addr),
    .req_byte_en(req_byte_en), .route_dest_r(route_dest_r), .route_valid_r(route_valid_r),
    .inorder_queue_depth(inorder_queue_depth), .front_bus_freq_select(front_bus_freq_select),
    .illegal_combination(illegal_combination));
  bridge_side_model bridge_side_model_inst (
    .vga_on(vga_on), .isa_on(isa_on), .want_present(want_present), .vga_enable(vga_enable),
    .isa_enable(isa_enable), .io_window_base(io_window_base), .io_window_limit(io_window_limit),
    .present_wdata(present_wdata));

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // The run needs well under 200 cycles; a hang is cut off far beyond that.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 1000) begin
      n_mismatch++;
      close_out;
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Raise power good once per code; the patterns keep every strap bit distinct from the others.
  task automatic t_straps;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      power_good <= 1'b0;
      {graphics_port_strap, host_addr7_strap_pin, bus_speed_select_pins} <= {~i[0], i[1] ^ i[0], i[1:0]};
      repeat (2) @(posedge clk_sys);
      power_good <= 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      chk("cfg_rdata", {4'h0, ~i[0], i[1] ^ i[0], i[1:0]}, cfg_rdata);
      chk("freq", {6'h0, i[1:0]}, {6'h0, front_bus_freq_select});
      chk("depth", (i[1] ^ i[0]) ? 8'h0C : 8'h01, {4'h0, inorder_queue_depth});
    end
    // Pins move and software writes all ones with VGA clear; only the present bit changes, and is flagged.
    @(posedge clk_sys);
    bus_speed_select_pins <= 2'h0;
    cfg_write <= 1'b1;
    cfg_wdata <= 8'hFF;
    @(posedge clk_sys);
    cfg_write <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("cfg_rdata", 8'h23, cfg_rdata);
    chk("illegal_combination", 8'h01, {7'h0, illegal_combination});
    $display("t_straps done");
  endtask

  task automatic set_mode(input logic vga, input logic pres, input logic isa);
    @(posedge clk_sys);
    vga_on <= vga;
    isa_on <= isa;
    want_present <= pres;
    @(posedge clk_sys);
    cfg_write <= 1'b1;
    cfg_wdata <= present_wdata;
    @(posedge clk_sys);
    cfg_write <= 1'b0;
    #1;
    chk("present", {7'h0, pres & vga}, {7'h0, cfg_rdata[5]});
    chk("illegal_combination", 8'h00, {7'h0, illegal_combination});
  endtask

  task automatic route(input logic io, input logic [31:0] addr, input logic [3:0] be, input logic [1:0] exp);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_is_io <= io;
    req_addr <= addr;
    req_byte_en <= be;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    #1;
    chk("route_valid_r", 8'h01, {7'h0, route_valid_r});
    chk("route_dest_r", {6'h0, exp}, {6'h0, route_dest_r});
  endtask

  // Both enables clear, ISA only, VGA only, and VGA with the present bit, against the legacy ranges.
  task automatic t_route;
    set_mode(1'b0, 1'b0, 1'b0);
    route(1'b1, 32'h3BC, 4'h1, 2'h2);
    route(1'b0, 32'hB0000, 4'h0, 2'h1);
    set_mode(1'b0, 1'b0, 1'b1);
    route(1'b1, 32'h3BC, 4'h1, 2'h1);
    set_mode(1'b1, 1'b0, 1'b0);
    route(1'b1, 32'h3BC, 4'h8, 2'h1);
    route(1'b1, 32'h3B4, 4'h1, 2'h2);
    set_mode(1'b1, 1'b1, 1'b0);
    route(1'b1, 32'hFFB4, 4'h1, 2'h1);
    route(1'b1, 32'h3B4, 4'hE, 2'h1);
    route(1'b1, 32'h3B4, 4'hC, 2'h2);
    route(1'b0, 32'hB7FFF, 4'h0, 2'h1);
    route(1'b0, 32'hB8000, 4'h0, 2'h2);
    $display("t_route done");
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("cfg_rdata", 8'h00, cfg_rdata);
    chk("depth", 8'h01, {4'h0, inorder_queue_depth});
    t_straps;
    t_route;
    close_out;
  end
endmodule

// [legacy_route_assertions.sv]
`timescale 1ns/1ps
module legacy_route_assertions (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       cfg_write,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic       power_good,
  input wire logic       graphics_port_strap,
  input wire logic       host_addr7_strap_pin,
  input wire logic [1:0] bus_speed_select_pins,
  input wire logic       req_valid,
  input wire logic [1:0] route_dest_r,
  input wire logic       route_valid_r,
  input wire logic [3:0] inorder_queue_depth,
  input wire logic [1:0] front_bus_freq_select
);
  // One clock domain, so clocking and reset are given once.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Route answers follow the request by exactly one cycle.
  a_route_one_late: assert property (req_valid |=> route_valid_r && route_dest_r != 2'h0)
    else $error("route answer missing");
  a_route_idle_quiet: assert property (!req_valid |=> !route_valid_r)
    else $error("route answer without request");
  // The present bit follows a write and holds otherwise.
  a_present_write: assert property (cfg_write |=> cfg_rdata[5] == $past(cfg_wdata[5]))
    else $error("present bit not written");
  a_present_hold: assert property (!cfg_write |=> $stable(cfg_rdata[5]))
    else $error("present bit moved");
  // Straps land one cycle after power good rises and are checked at two; the bench holds them steady meanwhile.
  a_strap_capture: assert property ($rose(power_good) |-> ##2 cfg_rdata[3:0] ==
    {graphics_port_strap, host_addr7_strap_pin, bus_speed_select_pins})
    else $error("straps not captured");
  a_strap_hold: assert property ($stable(power_good) [*3] |=> $stable(cfg_rdata[3:0]))
    else $error("strap fields moved");
  a_depth_code: assert property (inorder_queue_depth == (cfg_rdata[2] ? 4'hC : 4'h1))
    else $error("queue depth wrong");
  // The frequency code is the pin pair seen at the edge where power good rose, not a copy of the read view.
  a_freq_field: assert property ($rose(power_good) |=> front_bus_freq_select == $past(bus_speed_select_pins))
    else $error("frequency field wrong");
endmodule

bind legacy_route_and_strap_bits legacy_route_assertions legacy_route_assertions_inst (
  .clk_sys(clk_sys), .rst(rst), .cfg_write(cfg_write), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .power_good(power_good), .graphics_port_strap(graphics_port_strap),
  .host_addr7_strap_pin(host_addr7_strap_pin), .bus_speed_select_pins(bus_speed_select_pins),
  .req_valid(req_valid), .route_dest_r(route_dest_r), .route_valid_r(route_valid_r),
  .inorder_queue_depth(inorder_queue_depth), .front_bus_freq_select(front_bus_freq_select));

// [legacy_route_pkg.sv]
package legacy_route_pkg;
  // Bit positions in the low byte of the configuration word.
  localparam int MONO_PRESENT_BIT = 5;
  localparam int GFX_MODE_BIT     = 3;
  localparam int QUEUE_DEPTH_BIT  = 2;
  localparam int FREQ_MSB         = 1;
  localparam int FREQ_LSB         = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Monochrome adapter memory window.
  localparam logic [31:0] MONO_MEM_LO = 32'h000B0000;
  localparam logic [31:0] MONO_MEM_HI = 32'h000B7FFF;

  // Monochrome adapter I/O locations, compared on A[9:0] only.
  localparam logic [9:0] MONO_IO_3B4 = 10'h3B4;
  localparam logic [9:0] MONO_IO_3B5 = 10'h3B5;
  localparam logic [9:0] MONO_IO_3B8 = 10'h3B8;
  localparam logic [9:0] MONO_IO_3B9 = 10'h3B9;
  localparam logic [9:0] MONO_IO_3BA = 10'h3BA;
  localparam logic [9:0] MONO_IO_3BF = 10'h3BF;
  localparam logic [9:0] PORT_3BC    = 10'h3BC;

  // VGA compatible ranges.
  localparam logic [31:0] VGA_MEM_LO = 32'h000A0000;
  localparam logic [31:0] VGA_MEM_HI = 32'h000BFFFF;
  localparam logic [9:0]  VGA_IO_LO  = 10'h3B0;
  localparam logic [9:0]  VGA_IO_HI  = 10'h3DF;

  // In-order queue depths selected by the strap.
  localparam logic [3:0] QUEUE_DEPTH_SHALLOW = 4'h1;
  localparam logic [3:0] QUEUE_DEPTH_DEEP    = 4'hC;

  // Front bus frequency codes.
  typedef enum logic [1:0] {
    FREQ_100_400 = 2'h0,
    FREQ_133_533 = 2'h1,
    FREQ_200_800 = 2'h2,
    FREQ_RESERVED = 2'h3
  } bus_freq_type;

  // Destination of a routed access.
  typedef enum logic [1:0] {
    DEST_NONE,
    DEST_HUB,
    DEST_GRAPHICS
  } dest_type;
endpackage

// [strap_capture.sv]
`timescale 1ns/1ps
// Latches strap pins on the rising edge of power good; holds them otherwise.
module strap_capture #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             power_good,
  input  wire logic [WIDTH-1:0] strap_in,
  output logic      [WIDTH-1:0] strap_r
);
  logic             power_good_d_r;
  logic             power_good_d_nxt;
  logic [WIDTH-1:0] strap_nxt;

  // Capture only on a low-to-high transition so software and later pin motion cannot disturb it.
  always_comb begin
    power_good_d_nxt = power_good;
    strap_nxt        = strap_r;
    if (power_good && !power_good_d_r) begin
      strap_nxt = strap_in;
    end
  end

  // Registers reset to zero; the strap value itself is only ever taken by the clock.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      power_good_d_r <= 1'b0;
      strap_r        <= '0;
    end else begin
      power_good_d_r <= power_good_d_nxt;
      strap_r        <= strap_nxt;
    end
  end
endmodule
